// ---- inc/adc_sel_params.svh ----
// register offsets, field positions, reset values and codes of the converter input/reference selection block
// assumes an 8-bit register port with a 4-bit word address
`ifndef ADC_SEL_PARAMS_SVH
`define ADC_SEL_PARAMS_SVH

`define ADDR_CONV_FIRST 4'h0
`define ADDR_CONV_SECOND 4'h1
`define ADDR_AMP_REF 4'h2
`define ADDR_BANDGAP 4'h3
`define ADDR_FUNC_LOW0 4'h4
`define ADDR_FUNC_LOW1 4'h5
`define ADDR_FUNC_HIGH0 4'h6
`define ADDR_FUNC_HIGH1 4'h7

`define CHAN_SEL_LSB 0
`define CHAN_SEL_MSB 3
`define SRC_SEL_LSB 4
`define SRC_SEL_MSB 7
`define PGA_EN_BIT 7
`define PGA_IN_BIT 4
`define REF_SEL_LSB 2
`define REF_SEL_MSB 3
`define GAIN_SEL_LSB 0
`define GAIN_SEL_MSB 1
`define BANDGAP_EN_BIT 0

`define RST_CONV_FIRST 8'h00
`define RST_CONV_SECOND 8'h00
`define RST_AMP_REF 8'h00
`define RST_BANDGAP 8'h00
`define RST_FUNC 12'h000

`define NUM_CHANNELS 12
`define LAST_CHANNEL 4'hb
`define FUNC_ANALOG 2'h3

`endif

// ---- inc/adc_sel_pkg.sv ----
// types shared by the converter input/reference selection block
// assumes adc_sel_params.svh is compiled alongside
package adc_sel_pkg;

  typedef enum logic [1:0] {REF_AVDD, REF_PIN, REF_PGA} ref_src_t;

  typedef struct packed {
    logic avdd;
    logic ext_pin;
    logic pga_out;
  } ref_switch_t;

  typedef struct packed {
    logic avdd_full;
    logic avdd_half;
    logic avdd_quarter;
    logic pga_full;
    logic pga_half;
    logic pga_quarter;
    logic ground;
  } int_switch_t;

  typedef struct packed {
    logic from_pin;
    logic from_bandgap;
  } pga_input_t;

endpackage : adc_sel_pkg

// ---- hw/pin_share_ctrl.sv ----
// per-pin sharing overrides for the analog channel pins
// assumes function codes and port requests come from logic on the same clock
`timescale 1ns/1ps
`include "adc_sel_params.svh"

module pin_share_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] func_low,
  input wire logic [11:0] func_high,
  input wire logic [11:0] pull_high_req,
  input wire logic [11:0] dir_output_req,
  output logic [11:0] analog_pin_en,
  output logic [11:0] pull_high_en,
  output logic [11:0] pin_drive_en
);
  import adc_sel_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `NUM_CHANNELS; i = i + 1) begin : g_pin
      logic analog;
      assign analog = ({func_high[i], func_low[i]} == `FUNC_ANALOG);

      // an analog pin drops every digital function at once
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          analog_pin_en[i] <= 1'b0;
          pull_high_en[i] <= 1'b0;
          pin_drive_en[i] <= 1'b0;
        end else begin
          analog_pin_en[i] <= analog;
          pull_high_en[i] <= pull_high_req[i] & ~analog;
          pin_drive_en[i] <= dir_output_req[i] & ~analog;
        end
      end
    end
  endgenerate

endmodule : pin_share_ctrl

// ---- hw/adc_ref_select.sv ----
// register file and switch decoding for the converter input and reference selection
// assumes a single-cycle register port on clk; analog switches sit outside this logic
`timescale 1ns/1ps
`include "adc_sel_params.svh"

// Notes on behaviour
// - pga_enable bit 7 powers the reference amplifier on when set.
// - amplifier register bits 6 and 5 read zero and ignore writes.
// - pga_input_select 0 takes the external pin, 1 takes the bandgap.
// - selecting the bandgap disconnects the external amplifier input pin.
// - reference_select 00 supply, 01 external pin, 1x amplifier output.
// - an internal reference disconnects the external reference pin.
// - gain_select picks gains 1, 1.667, 2.5, 3.333.
// - bandgap register holds enable at bit 0, bits 7 to 1 read zero.
// - an analog pin has all its other functions disabled.
// - register pull-high is dropped while a pin is analog.
// - analog selection overrides the pin's direction control.
// - source codes 0000, 0100, 11xx convert the selected external channel.
// - other source codes pick supply, amplifier fractions or ground.
// - an internal source disconnects every external channel.
// - channel codes 0000 to 1011 pick pins, 1100 to 1111 float.
// - input_source_select sits in bits 7 to 4, reset zero.
// - channel_select sits in bits 3 to 0, reset zero.
module adc_ref_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  input wire logic [11:0] pull_high_req,
  input wire logic [11:0] dir_output_req,
  output logic [11:0] analog_pin_en,
  output logic [11:0] pull_high_en,
  output logic [11:0] pin_drive_en,
  output logic pga_enable,
  output logic bandgap_enable,
  output adc_sel_pkg::pga_input_t pga_input,
  output adc_sel_pkg::ref_switch_t ref_switch,
  output logic [3:0] gain_onehot,
  output logic [11:0] channel_switch,
  output adc_sel_pkg::int_switch_t int_switch
);
  import adc_sel_pkg::*;

  logic [3:0] channel_select_reg;
  logic [3:0] input_source_reg;
  logic pga_enable_reg;
  logic pga_input_reg;
  logic [1:0] reference_select_reg;
  logic [1:0] gain_select_reg;
  logic bandgap_enable_reg;
  logic [11:0] func_low_reg;
  logic [11:0] func_high_reg;

  logic [7:0] rd_data_next;
  logic external_mode;
  ref_src_t ref_src;
  ref_switch_t ref_switch_next;
  int_switch_t int_switch_next;
  pga_input_t pga_input_next;
  logic [11:0] channel_switch_next;
  logic [3:0] gain_onehot_next;
  logic [15:0] gain_decoded;
  logic [15:0] channel_decoded;

  // one decoder serves both the channel and the gain fields
  function automatic logic [15:0] onehot16(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    v[code] = 1'b1;
    return v;
  endfunction : onehot16

  function automatic logic write_hit(input logic [3:0] a, input logic [3:0] target, input logic wr);
    return wr && (a == target);
  endfunction : write_hit

  // converter first control: only the channel field lives here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_select_reg <= 4'(`RST_CONV_FIRST >> `CHAN_SEL_LSB);
    end else if (write_hit(addr, `ADDR_CONV_FIRST, wr_strobe)) begin
      channel_select_reg <= wdata[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
    end
  end

  // converter second control: the source field
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_source_reg <= 4'(`RST_CONV_SECOND >> `SRC_SEL_LSB);
    end else if (write_hit(addr, `ADDR_CONV_SECOND, wr_strobe)) begin
      input_source_reg <= wdata[`SRC_SEL_MSB:`SRC_SEL_LSB];
    end
  end

  // amplifier/reference control; bits 6 and 5 have no storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pga_enable_reg <= 1'(`RST_AMP_REF >> `PGA_EN_BIT);
      pga_input_reg <= 1'(`RST_AMP_REF >> `PGA_IN_BIT);
      reference_select_reg <= 2'(`RST_AMP_REF >> `REF_SEL_LSB);
      gain_select_reg <= 2'(`RST_AMP_REF >> `GAIN_SEL_LSB);
    end else if (write_hit(addr, `ADDR_AMP_REF, wr_strobe)) begin
      pga_enable_reg <= wdata[`PGA_EN_BIT];
      pga_input_reg <= wdata[`PGA_IN_BIT];
      reference_select_reg <= wdata[`REF_SEL_MSB:`REF_SEL_LSB];
      gain_select_reg <= wdata[`GAIN_SEL_MSB:`GAIN_SEL_LSB];
    end
  end

  // bandgap control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bandgap_enable_reg <= 1'(`RST_BANDGAP >> `BANDGAP_EN_BIT);
    end else if (write_hit(addr, `ADDR_BANDGAP, wr_strobe)) begin
      bandgap_enable_reg <= wdata[`BANDGAP_EN_BIT];
    end
  end

  // pin function codes; two bits per pin split over low and high banks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      func_low_reg <= `RST_FUNC;
    end else begin
      if (write_hit(addr, `ADDR_FUNC_LOW0, wr_strobe)) begin
        func_low_reg[7:0] <= wdata;
      end
      if (write_hit(addr, `ADDR_FUNC_LOW1, wr_strobe)) begin
        func_low_reg[11:8] <= wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      func_high_reg <= `RST_FUNC;
    end else begin
      if (write_hit(addr, `ADDR_FUNC_HIGH0, wr_strobe)) begin
        func_high_reg[7:0] <= wdata;
      end
      if (write_hit(addr, `ADDR_FUNC_HIGH1, wr_strobe)) begin
        func_high_reg[11:8] <= wdata[3:0];
      end
    end
  end

  // read mux; unmapped addresses and unimplemented bits read zero
  always_comb begin
    rd_data_next = 8'h00;
    case (addr)
      `ADDR_CONV_FIRST: begin
        rd_data_next[`CHAN_SEL_MSB:`CHAN_SEL_LSB] = channel_select_reg;
      end
      `ADDR_CONV_SECOND: begin
        rd_data_next[`SRC_SEL_MSB:`SRC_SEL_LSB] = input_source_reg;
      end
      `ADDR_AMP_REF: begin
        rd_data_next[`PGA_EN_BIT] = pga_enable_reg;
        rd_data_next[`PGA_IN_BIT] = pga_input_reg;
        rd_data_next[`REF_SEL_MSB:`REF_SEL_LSB] = reference_select_reg;
        rd_data_next[`GAIN_SEL_MSB:`GAIN_SEL_LSB] = gain_select_reg;
        rd_data_next[6:5] = 2'h0;
      end
      `ADDR_BANDGAP: begin
        rd_data_next[`BANDGAP_EN_BIT] = bandgap_enable_reg;
        rd_data_next[7:1] = 7'h00;
      end
      `ADDR_FUNC_LOW0: begin
        rd_data_next = func_low_reg[7:0];
      end
      `ADDR_FUNC_LOW1: begin
        rd_data_next = {4'h0, func_low_reg[11:8]};
      end
      `ADDR_FUNC_HIGH0: begin
        rd_data_next = func_high_reg[7:0];
      end
      `ADDR_FUNC_HIGH1: begin
        rd_data_next = {4'h0, func_high_reg[11:8]};
      end
      default: begin
        rd_data_next = 8'h00;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_strobe) begin
      rd_data <= rd_data_next;
    end else begin
      rd_data <= 8'h00;
    end
  end

  // amplifier input: the pin switch opens whenever the bandgap is picked
  always_comb begin
    pga_input_next.from_pin = ~pga_input_reg;
    pga_input_next.from_bandgap = pga_input_reg;
  end

  // reference source; 1x ignores the low bit
  always_comb begin
    if (reference_select_reg[1]) begin
      ref_src = REF_PGA;
    end else if (reference_select_reg[0]) begin
      ref_src = REF_PIN;
    end else begin
      ref_src = REF_AVDD;
    end
  end

  always_comb begin
    ref_switch_next = '0;
    case (ref_src)
      REF_AVDD: begin
        ref_switch_next.avdd = 1'b1;
      end
      REF_PIN: begin
        ref_switch_next.ext_pin = 1'b1;
      end
      REF_PGA: begin
        ref_switch_next.pga_out = 1'b1;
      end
      default: begin
        ref_switch_next = '0;
      end
    endcase
  end

  always_comb begin
    gain_decoded = onehot16({2'h0, gain_select_reg});
    gain_onehot_next = gain_decoded[3:0];
  end

  // source decode: external for 0000, 0100 and 11xx
  always_comb begin
    external_mode = (input_source_reg == 4'h0) || (input_source_reg == 4'h4)
      || (input_source_reg[3:2] == 2'h3);
  end

  always_comb begin
    int_switch_next = '0;
    case (input_source_reg)
      4'h1: begin
        int_switch_next.avdd_full = 1'b1;
      end
      4'h2: begin
        int_switch_next.avdd_half = 1'b1;
      end
      4'h3: begin
        int_switch_next.avdd_quarter = 1'b1;
      end
      4'h5: begin
        int_switch_next.pga_full = 1'b1;
      end
      4'h6: begin
        int_switch_next.pga_half = 1'b1;
      end
      4'h7: begin
        int_switch_next.pga_quarter = 1'b1;
      end
      4'h8, 4'h9, 4'ha, 4'hb: begin
        int_switch_next.ground = 1'b1;
      end
      default: begin
        int_switch_next = '0;
      end
    endcase
  end

  // channel codes past the last pin leave the input floating
  always_comb begin
    channel_decoded = onehot16(channel_select_reg);
    if (external_mode && (channel_select_reg <= `LAST_CHANNEL)) begin
      channel_switch_next = channel_decoded[11:0];
    end else begin
      channel_switch_next = 12'h000;
    end
  end

  // switch enables are registered so every output leaves a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_switch <= 12'h000;
      int_switch <= '0;
    end else begin
      channel_switch <= channel_switch_next;
      int_switch <= int_switch_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_switch <= '0;
    end else begin
      ref_switch <= ref_switch_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_onehot <= 4'h0;
    end else begin
      gain_onehot <= gain_onehot_next;
    end
  end

  // both amplifier input switches stay open while in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pga_input <= '0;
    end else begin
      pga_input <= pga_input_next;
    end
  end

  // power enables follow their bits; no interlock with the bandgap, software orders that
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pga_enable <= 1'b0;
    end else begin
      pga_enable <= pga_enable_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bandgap_enable <= 1'b0;
    end else begin
      bandgap_enable <= bandgap_enable_reg;
    end
  end

  pin_share_ctrl u_pin_share (
    .clk(clk),
    .rst(rst),
    .func_low(func_low_reg),
    .func_high(func_high_reg),
    .pull_high_req(pull_high_req),
    .dir_output_req(dir_output_req),
    .analog_pin_en(analog_pin_en),
    .pull_high_en(pull_high_en),
    .pin_drive_en(pin_drive_en)
  );

endmodule : adc_ref_select

// ---- dv/adc_sel_asserts.sv ----
// checker for the input/reference selection block, bound to its top module
// assumes one clock, async active-high reset, registered decode one cycle behind the registers
`timescale 1ns/1ps
module adc_sel_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_data,
  input wire logic [11:0] pull_high_req,
  input wire logic [11:0] dir_output_req,
  input wire logic [11:0] analog_pin_en,
  input wire logic [11:0] pull_high_en,
  input wire logic [11:0] pin_drive_en,
  input wire logic pga_enable,
  input wire logic bandgap_enable,
  input wire adc_sel_pkg::pga_input_t pga_input,
  input wire adc_sel_pkg::ref_switch_t ref_switch,
  input wire logic [3:0] gain_onehot,
  input wire logic [11:0] channel_switch,
  input wire adc_sel_pkg::int_switch_t int_switch
);
  import adc_sel_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  amp_rsvd_a: assert property ($past(rd_strobe) && $past(addr) == 4'h2 |-> rd_data[6:5] == 2'b00)
    else $error("amp reserved bits read nonzero");
  bg_rsvd_a: assert property ($past(rd_strobe) && $past(addr) == 4'h3 |-> rd_data[7:1] == 7'h00)
    else $error("bandgap reserved bits read nonzero");
  pga_en_a: assert property (wr_strobe && addr == 4'h2 ##1 !(wr_strobe && addr == 4'h2)
    |=> pga_enable == $past(wdata[7], 2))
    else $error("amplifier enable does not follow write");
  bg_en_a: assert property (wr_strobe && addr == 4'h3 ##1 !(wr_strobe && addr == 4'h3)
    |=> bandgap_enable == $past(wdata[0], 2))
    else $error("bandgap enable does not follow write");
  ref_hot_a: assert property (!$past(rst) |-> $onehot(ref_switch))
    else $error("reference switch not one-hot");
  pga_in_a: assert property (!$past(rst) |-> $onehot(pga_input))
    else $error("amplifier input not one-hot");
  gain_hot_a: assert property (!$past(rst) |-> $onehot(gain_onehot))
    else $error("gain select not one-hot");
  int_excl_a: assert property (|int_switch |-> channel_switch == 12'h000 && $onehot(int_switch))
    else $error("external channel on beside internal source");
  pull_mask_a: assert property (!$past(rst) && $stable(analog_pin_en)
    |-> pull_high_en == ($past(pull_high_req) & ~analog_pin_en))
    else $error("pull-high not masked by analog pin");
  drive_mask_a: assert property (!$past(rst) && $stable(analog_pin_en)
    |-> pin_drive_en == ($past(dir_output_req) & ~analog_pin_en))
    else $error("drive not overridden by analog pin");
endmodule : adc_sel_asserts

bind adc_ref_select adc_sel_asserts u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .pull_high_req(pull_high_req),
  .dir_output_req(dir_output_req), .analog_pin_en(analog_pin_en), .pull_high_en(pull_high_en),
  .pin_drive_en(pin_drive_en), .pga_enable(pga_enable), .bandgap_enable(bandgap_enable),
  .pga_input(pga_input), .ref_switch(ref_switch), .gain_onehot(gain_onehot),
  .channel_switch(channel_switch), .int_switch(int_switch));

// ---- dv/tb_top.sv ----
// register-level bench for the input/reference selection block
// assumes the checker is bound separately; bench drives the port-logic wishes itself
`timescale 1ns/1ps
module tb_top;
  import adc_sel_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rd_data;
  logic [7:0] v;
  logic [11:0] pull_high_req = 12'hfff;
  logic [11:0] dir_output_req = 12'hfff;
  logic [11:0] analog_pin_en;
  logic [11:0] pull_high_en;
  logic [11:0] pin_drive_en;
  logic [11:0] channel_switch;
  logic pga_enable;
  logic bandgap_enable;
  pga_input_t pga_input;
  ref_switch_t ref_switch;
  int_switch_t int_switch;
  logic [6:0] e;
  logic [3:0] gain_onehot;
  logic [3:0] s;
  logic [3:0] c;
  int n_errors = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  adc_ref_select DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .pull_high_req(pull_high_req),
    .dir_output_req(dir_output_req), .analog_pin_en(analog_pin_en), .pull_high_en(pull_high_en),
    .pin_drive_en(pin_drive_en), .pga_enable(pga_enable), .bandgap_enable(bandgap_enable),
    .pga_input(pga_input), .ref_switch(ref_switch), .gain_onehot(gain_onehot),
    .channel_switch(channel_switch), .int_switch(int_switch));
  task chk(input string n, input logic [11:0] ex, input logic [11:0] g);
    cmp_count++;
    if (g !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, ex, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_strobe <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [3:0] a, input logic [7:0] ex);
    @(posedge clk);
    rd_strobe <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    chk("rd_data", 12'(ex), 12'(rd_data));
  endtask : rd
  task settle;
    @(posedge clk);
    #1;
  endtask : settle
  function logic [6:0] int_exp(input logic [3:0] sv);
    case (sv)
      4'h1: return 7'h40;
      4'h2: return 7'h20;
      4'h3: return 7'h10;
      4'h5: return 7'h08;
      4'h6: return 7'h04;
      4'h7: return 7'h02;
      4'h8, 4'h9, 4'ha, 4'hb: return 7'h01;
      default: return 7'h00;
    endcase
  endfunction : int_exp
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    settle;
    settle;
    chk("ref", 12'h4, 12'(ref_switch));
    chk("gain", 12'h1, 12'(gain_onehot));
    chk("chan", 12'h001, channel_switch);
    chk("pgain", 12'h2, 12'(pga_input));
    for (int i = 0; i < 8; i++) rd(i[3:0], 8'h00);
    wr(4'hc, 8'hff);
    rd(4'hc, 8'h00);
    // pin sharing is set up before any reference pin is used
    wr(4'h4, 8'hff);
    wr(4'h5, 8'hff);
    wr(4'h6, 8'h0f);
    wr(4'h7, 8'h0a);
    rd(4'h5, 8'h0f);
    chk("analog", 12'ha0f, analog_pin_en);
    chk("pull", 12'h5f0, pull_high_en);
    chk("drive", 12'h5f0, pin_drive_en);
    @(posedge clk);
    pull_high_req <= 12'h0f0;
    dir_output_req <= 12'h00f;
    wr(4'h6, 8'h00);
    settle;
    chk("analog", 12'ha00, analog_pin_en);
    chk("pull", 12'h0f0, pull_high_en);
    chk("drive", 12'h00f, pin_drive_en);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h01);
    chk("bg", 12'h1, 12'(bandgap_enable));
    // let the bandgap start up before the amplifier is switched onto it
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      v = {i[1], 2'b11, i[0], i[1:0], i[1:0]};
      wr(4'h2, v);
      rd(4'h2, v & 8'h9f);
      chk("pga_en", 12'(i[1]), 12'(pga_enable));
      chk("pgain", i[0] ? 12'h1 : 12'h2, 12'(pga_input));
      chk("ref", i[1] ? 12'h1 : (i[0] ? 12'h2 : 12'h4), 12'(ref_switch));
      chk("gain", 12'h1 << i, 12'(gain_onehot));
    end
    // channel code runs through 11 and 15 on external source codes
    for (int i = 0; i < 16; i++) begin
      s = i[3:0];
      c = s ^ 4'hb;
      e = int_exp(s);
      wr(4'h0, {4'hf, c});
      wr(4'h1, {s, 4'hf});
      rd(4'h0, {4'h0, c});
      rd(4'h1, {s, 4'h0});
      chk("int", 12'(e), 12'(int_switch));
      chk("chan", (e == 7'h0 && c < 4'hc) ? 12'h1 << c : 12'h0, channel_switch);
    end
    // reset spans two edges so no checker sees cleared switches outside reset
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle;
    settle;
    chk("chan", 12'h001, channel_switch);
    rd(4'h2, 8'h00);
    // decoded switches follow a write one cycle after the register takes it
    wr(4'h2, 8'h08);
    #1;
    chk("ref", 12'h4, 12'(ref_switch));
    settle;
    chk("ref", 12'h1, 12'(ref_switch));
    end_sim;
  end
endmodule : tb_top
